//--- hw/csm_clock_ctrl.sv
// Clock synthesizer mode, gating and wakeup controller with APB registers
//
// Overview of operation
// R1: Normal synthesizer multiplies reference by two to nine.
// R2: Post divider lowers frequency without disturbing the loop.
// R3: Reference is crystal oscillator or external clock.
// R4: Unity mode gives system frequency equal to reference.
// R5: Unity mode ignores the post divider.
// R6: External mode bypasses synthesizer, uses reference pin directly.
// R7: Wakeup runs flash clock at least sixteen cycles before core clocks.
// R8: Wait and doze keep peripherals, stop processor, flash, RAM.
// R9: Each peripheral may gate its own clock locally.
// R10: Stop mode disables every system clock.
// R11: Synthesizer off in stop needs relock wait on wakeup.
// R12: Oscillator off in stop needs restart wait on wakeup.
// R13: Stop setting 00 keeps clock output pin running.
// R14: Fast wakeup enables clocks at once on stop recovery.
// R15: Software should raise post divider by one before fast-wakeup stop.
// R16: External mode applies no oscillator or lock wait.
// R17: Clock output pin copies the system clock.
// R18: Outside party drives reference pin unless crystal is used.
// R19: Stop field 00,01,10,11 progressively stops output, synthesizer, oscillator.
// R20: Without fast wakeup, clocks wait for lock on stop wakeup.
// R21: Clock output disable holds the pin low.
// R22: Mode is latched at reset and held until next reset.
`timescale 1ns/10ps
`default_nettype none
module csm_clock_ctrl
  import csm_pkg::*;
#(
  parameter int unsigned RELOCK_CYCLES = RELOCK_CYC,
  parameter int unsigned OSC_CYCLES = OSC_RESTART_CYC
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [1:0] mode_strap_in,
  input wire logic use_crystal_in,
  input wire logic [1:0] power_req_in,
  input wire logic synth_locked_in,
  input wire logic [3:0] periph_local_en_in,
  input wire logic sys_clk_in,
  output logic [3:0] periph_clk_en_out,
  output logic cpu_clk_en_out,
  output logic flash_clk_en_out,
  output logic ram_clk_en_out,
  output logic sys_clock_out,
  output logic synth_enable_out,
  output logic osc_enable_out,
  output logic synth_bypass_out,
  output logic ref_from_crystal_out,
  output logic [MFD_W-1:0] feedback_multiplier_out,
  output logic [RFD_W-1:0] post_divide_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_s1_r;
  logic rst_r;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1_r <= 1'b0;
      rst_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_r <= rst_s1_r;
    end
  end
  wire logic rst_n = rst_r;

  ////////////////////////////////////////////////////////////////////////////
  // Mode latch: captured on first cycle after release
  csm_mode_t mode_r;
  logic mode_done_r;
  logic crystal_drive_out_r;
  wire csm_mode_t mode_nxt = (mode_strap_in == CSM_MODE_ONE) ? CSM_MODE_ONE :
                             (mode_strap_in == CSM_MODE_EXT) ? CSM_MODE_EXT : CSM_MODE_PLL;
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_r <= CSM_MODE_PLL;
      mode_done_r <= 1'b0;
      crystal_drive_out_r <= 1'b0;
    end
    else if (!mode_done_r)
    begin
      mode_r <= mode_nxt; // R22
      crystal_drive_out_r <= use_crystal_in && (mode_nxt == CSM_MODE_PLL); // R3 R18
      mode_done_r <= 1'b1;
    end
  end
  wire logic is_ext = (mode_r == CSM_MODE_EXT);
  wire logic is_one = (mode_r == CSM_MODE_ONE);

  ////////////////////////////////////////////////////////////////////////////
  // APB registers
  logic [MFD_W-1:0] mfd_r;
  logic [RFD_W-1:0] rfd_r;
  logic clock_out_disable_r;
  logic fast_wakeup_sel_r;
  logic [1:0] stp_r;
  csm_state_t st_r;
  csm_state_t st_nxt;
  wire logic wr = psel_in && penable_in && pwrite_in && (paddr_in == ADDR_CTRL);
  wire logic hit = (paddr_in == ADDR_CTRL) || (paddr_in == ADDR_STAT) ||
                   (paddr_in == ADDR_POWER);
  wire logic [31:0] ctrl_rd = {16'h0000, 1'b0, mfd_r, 1'b0, rfd_r, 1'b0, clock_out_disable_r, fast_wakeup_sel_r,
                               1'b0, stp_r, 2'h0};
  wire logic [31:0] stat_rd = {24'h000000, 1'b0, st_r, synth_locked_in, crystal_drive_out_r, mode_r};
  wire logic [31:0] rd_nxt = (paddr_in == ADDR_CTRL) ? ctrl_rd :
                             (paddr_in == ADDR_STAT) ? stat_rd :
                             (paddr_in == ADDR_POWER) ? {30'h0, power_req_in} : 32'h0;
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mfd_r <= MFD_RST;
      rfd_r <= RFD_RST;
      clock_out_disable_r <= 1'b0;
      fast_wakeup_sel_r <= 1'b0;
      stp_r <= STP_ALL_ON;
      prdata_out <= 32'h0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else
    begin
      pready_out <= psel_in && !pready_out;
      pslverr_out <= psel_in && !pready_out && !hit;
      prdata_out <= (psel_in && !pwrite_in) ? rd_nxt : 32'h0;
      if (wr && pready_out)
      begin
        mfd_r <= pwdata_in[B_MFD +: MFD_W]; // R1
        rfd_r <= pwdata_in[B_RFD +: RFD_W]; // R2
        clock_out_disable_r <= pwdata_in[B_CLOCK_OUT_DISABLE];
        fast_wakeup_sel_r <= pwdata_in[B_FAST_WAKEUP_SEL];
        stp_r <= pwdata_in[B_STP +: 2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power sequencer
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [1:0] stp_held_r;
  wire logic pll_off = !is_ext && (stp_held_r >= STP_NO_PLL);
  wire logic osc_off = !is_ext && (stp_held_r == STP_NO_OSC) && crystal_drive_out_r;
  wire logic [CNT_W-1:0] recov_len = osc_off ? CNT_W'(OSC_CYCLES + RELOCK_CYCLES) : // R12
                                    pll_off ? CNT_W'(RELOCK_CYCLES) : CNT_W'(0); // R11
  wire logic lock_ok = is_ext || synth_locked_in; // R16
  wire logic recov_done = (cnt_r == CNT_W'(0)) && (fast_wakeup_sel_r || lock_ok); // R20
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = (cnt_r != CNT_W'(0)) ? cnt_r - CNT_W'(1) : cnt_r;
    unique case (st_r)
      CSM_ST_RUN:
      begin
        if (power_req_in == CSM_PWR_STOP)
          st_nxt = CSM_ST_STOP;
        else if (power_req_in != CSM_PWR_RUN)
          st_nxt = CSM_ST_LOW;
      end
      CSM_ST_LOW:
      begin
        if (power_req_in == CSM_PWR_RUN)
        begin
          st_nxt = CSM_ST_FLASH;
          cnt_nxt = CNT_W'(FLASH_HEAD_CYC - 1); // R7
        end
      end
      CSM_ST_STOP:
      begin
        if (power_req_in != CSM_PWR_STOP)
        begin
          if (fast_wakeup_sel_r || is_ext) // R14 R16
          begin
            st_nxt = CSM_ST_FLASH;
            cnt_nxt = CNT_W'(FLASH_HEAD_CYC - 1);
          end
          else
          begin
            st_nxt = CSM_ST_RECOV;
            cnt_nxt = recov_len;
          end
        end
      end
      CSM_ST_RECOV:
      begin
        if (recov_done)
        begin
          st_nxt = CSM_ST_FLASH;
          cnt_nxt = CNT_W'(FLASH_HEAD_CYC - 1);
        end
      end
      CSM_ST_FLASH:
      begin
        if (cnt_r == CNT_W'(0))
          st_nxt = CSM_ST_RUN; // R7
      end
      default:
        st_nxt = CSM_ST_RUN;
    endcase
  end
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= CSM_ST_RUN;
      cnt_r <= CNT_W'(0);
      stp_held_r <= STP_ALL_ON;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      if (st_r == CSM_ST_RUN)
        stp_held_r <= stp_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gating outputs
  csm_gates_t g;
  assign g.cpu = (st_nxt == CSM_ST_RUN); // R8 R10
  assign g.ram = (st_nxt == CSM_ST_RUN);
  assign g.flash = (st_nxt == CSM_ST_RUN) || (st_nxt == CSM_ST_FLASH); // R7
  assign g.periph = (st_nxt != CSM_ST_STOP) && (st_nxt != CSM_ST_RECOV); // R8 R10
  wire logic in_stop = (st_nxt == CSM_ST_STOP);
  // Stop select as it will be held once the sequencer leaves run, so a late write counts
  wire logic [1:0] stp_eff = (st_r == CSM_ST_RUN) ? stp_r : stp_held_r;
  wire logic sys_clock_out_ok = !clock_out_disable_r && (!in_stop || (stp_eff == STP_ALL_ON)); // R13 R19 R21
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cpu_clk_en_out <= 1'b1;
      flash_clk_en_out <= 1'b1;
      ram_clk_en_out <= 1'b1;
      periph_clk_en_out <= 4'h0;
      sys_clock_out <= 1'b0;
      synth_enable_out <= 1'b1;
      osc_enable_out <= 1'b1;
      synth_bypass_out <= 1'b0;
      ref_from_crystal_out <= 1'b0;
      feedback_multiplier_out <= MFD_RST;
      post_divide_out <= RFD_RST;
    end
    else
    begin
      cpu_clk_en_out <= g.cpu;
      flash_clk_en_out <= g.flash;
      ram_clk_en_out <= g.ram;
      periph_clk_en_out <= {4{g.periph}} & periph_local_en_in; // R9
      sys_clock_out <= sys_clock_out_ok && sys_clk_in; // R17 R21
      synth_enable_out <= !is_ext && !(in_stop && stp_eff >= STP_NO_PLL); // R6 R19
      osc_enable_out <= !(in_stop && stp_eff == STP_NO_OSC); // R19
      synth_bypass_out <= is_ext; // R6
      ref_from_crystal_out <= crystal_drive_out_r; // R3
      feedback_multiplier_out <= is_one ? MFD_RST : mfd_r; // R1 R4
      post_divide_out <= (is_one || is_ext) ? '0 : rfd_r; // R2 R5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_flash_head;
    @(posedge clk_in) disable iff (!rst_n)
    $rose(st_r == CSM_ST_FLASH) |->
      (st_r == CSM_ST_FLASH) [*8] ##1 (st_r == CSM_ST_FLASH) [*8];
  endproperty
  a_flash_head: assert property (p_flash_head) else $error("flash head too short"); // R7
  property p_stop_off;
    @(posedge clk_in) disable iff (!rst_n)
    (st_r == CSM_ST_STOP) |-> !cpu_clk_en_out && !flash_clk_en_out && !ram_clk_en_out &&
      (periph_clk_en_out == '0);
  endproperty
  a_stop_off: assert property (p_stop_off) else $error("clock enabled in stop"); // R10
  property p_low_periph;
    @(posedge clk_in) disable iff (!rst_n)
    (st_r == CSM_ST_LOW) && (st_nxt == CSM_ST_LOW) |=> !cpu_clk_en_out && !ram_clk_en_out;
  endproperty
  a_low_periph: assert property (p_low_periph) else $error("core clock in wait"); // R8
  property p_clock_out_disable;
    @(posedge clk_in) disable iff (!rst_n)
    clock_out_disable_r |=> !sys_clock_out;
  endproperty
  a_clock_out_disable: assert property (p_clock_out_disable) else $error("clock out not held low"); // R21
  property p_fast;
    @(posedge clk_in) disable iff (!rst_n)
    (st_r == CSM_ST_STOP) && (power_req_in != CSM_PWR_STOP) && fast_wakeup_sel_r |=>
      (st_r == CSM_ST_FLASH);
  endproperty
  a_fast: assert property (p_fast) else $error("fast wakeup delayed"); // R14
  property p_one_div;
    @(posedge clk_in) disable iff (!rst_n)
    is_one && mode_done_r |=> (post_divide_out == '0);
  endproperty
  a_one_div: assert property (p_one_div) else $error("divider active in unity mode"); // R5
  property p_mode_hold;
    @(posedge clk_in) disable iff (!rst_n)
    mode_done_r |=> $stable(mode_r);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed"); // R22
  property p_ext_bypass;
    @(posedge clk_in) disable iff (!rst_n)
    is_ext |=> synth_bypass_out && !synth_enable_out;
  endproperty
  a_ext_bypass: assert property (p_ext_bypass) else $error("synth not bypassed"); // R6
endmodule : csm_clock_ctrl
`default_nettype wire

//--- hw/csm_pkg.sv
// Package for the clock synthesizer mode controller
package csm_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned FLASH_HEAD_CYC = 16;
  localparam int unsigned RELOCK_US = 200;
  localparam int unsigned OSC_RESTART_US = 1000;
  localparam int unsigned RELOCK_CYC = RELOCK_US * CLK_MHZ;
  localparam int unsigned OSC_RESTART_CYC = OSC_RESTART_US * CLK_MHZ;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned MFD_W = 3;
  localparam int unsigned RFD_W = 3;
  localparam int unsigned ACC_W = 8;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_STAT = 32'h0000_0004;
  localparam logic [31:0] ADDR_POWER = 32'h0000_0008;
  localparam int unsigned B_MFD = 12;
  localparam int unsigned B_RFD = 8;
  localparam int unsigned B_CLOCK_OUT_DISABLE = 6;
  localparam int unsigned B_FAST_WAKEUP_SEL = 5;
  localparam int unsigned B_STP = 2;
  localparam logic [2:0] MFD_RST = 3'h0;
  localparam logic [2:0] RFD_RST = 3'h1;
  localparam logic [1:0] STP_ALL_ON = 2'h0;
  localparam logic [1:0] STP_NO_SYS_CLOCK_OUT = 2'h1;
  localparam logic [1:0] STP_NO_PLL = 2'h2;
  localparam logic [1:0] STP_NO_OSC = 2'h3;
  typedef enum logic [1:0]
  {
    CSM_MODE_PLL = 2'h0,
    CSM_MODE_ONE = 2'h1,
    CSM_MODE_EXT = 2'h2
  } csm_mode_t;
  typedef enum logic [1:0]
  {
    CSM_PWR_RUN = 2'h0,
    CSM_PWR_WAIT = 2'h1,
    CSM_PWR_DOZE = 2'h2,
    CSM_PWR_STOP = 2'h3
  } csm_pwr_t;
  typedef enum logic [2:0]
  {
    CSM_ST_RUN = 3'h0,
    CSM_ST_LOW = 3'h1,
    CSM_ST_STOP = 3'h2,
    CSM_ST_RECOV = 3'h3,
    CSM_ST_FLASH = 3'h4
  } csm_state_t;
  typedef struct packed
  {
    logic cpu;
    logic flash;
    logic ram;
    logic periph;
  } csm_gates_t;
endpackage : csm_pkg

//--- verif/csm_ref_model.sv
// Reference clock source and synthesizer lock model
`timescale 1ns/10ps
`default_nettype none
module csm_ref_model
(
  input wire logic clk_in,
  input wire logic synth_en_in,
  output logic ref_clk_out,
  output logic locked_out
);
  localparam logic [3:0] LOCK_AT = 4'h8;
  logic [3:0] lock_cnt_r = 4'h0;
  initial ref_clk_out = 1'b0;
  // Reference runs free whether or not the block uses it
  always @(posedge clk_in) ref_clk_out <= ~ref_clk_out;
  // Lock drops while the loop is off, returns eight cycles after it restarts:
  // longer than the relock count, shorter than relock plus oscillator restart
  always @(posedge clk_in)
  begin
    if (!synth_en_in)
      lock_cnt_r <= 4'h0;
    else if (lock_cnt_r != LOCK_AT)
      lock_cnt_r <= lock_cnt_r + 4'h1;
  end
  assign locked_out = (lock_cnt_r == LOCK_AT);
endmodule : csm_ref_model
`default_nettype wire

//--- verif/csm_clock_ctrl_tb_top.sv
// Self-checking bench for the clock mode controller
`timescale 1ns/10ps
`default_nettype none
module csm_clock_ctrl_tb_top;
  import csm_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic pready, perr, rerr, lock, rclk, cpu, fl, ram, sclk, sen, oen, byp, crystal_drive_out;
  logic [1:0] strap = 2'h0;
  logic [1:0] preq = 2'h0;
  logic xsel = 1'b1;
  logic [3:0] plocal = 4'hA;
  logic [3:0] pce;
  logic [2:0] feedback_multiplier, post_divide_select;
  int mismatches = 0;
  int num_checks = 0;
  always #5 clk_in = ~clk_in;
  csm_clock_ctrl #(.RELOCK_CYCLES(5), .OSC_CYCLES(10)) dut_u (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(perr), .mode_strap_in(strap), .use_crystal_in(xsel),
    .power_req_in(preq), .synth_locked_in(lock), .periph_local_en_in(plocal),
    .sys_clk_in(rclk), .periph_clk_en_out(pce), .cpu_clk_en_out(cpu),
    .flash_clk_en_out(fl), .ram_clk_en_out(ram), .sys_clock_out(sclk),
    .synth_enable_out(sen), .osc_enable_out(oen), .synth_bypass_out(byp),
    .ref_from_crystal_out(crystal_drive_out), .feedback_multiplier_out(feedback_multiplier), .post_divide_out(post_divide_select));
  csm_ref_model ref_u (.clk_in(clk_in), .synth_en_in(sen), .ref_clk_out(rclk),
    .locked_out(lock));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rng(input int n, input int lo, input int hi);
    num_checks++;
    if (n < lo || n > hi)
    begin
      mismatches++;
      $display("[FAIL] %0t count %0d outside %0d..%0d", $time, n, lo, hi);
    end
  endtask : rng
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++)
      @(posedge clk_in);
    if (i == 20)
    begin
      mismatches++;
      $display("[FAIL] %0t bus transfer timeout", $time);
      end_sim();
    end
    rdat = prdata;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask : apb
  task automatic reset(input logic [1:0] s);
    @(posedge clk_in);
    strap <= s;
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (5) @(posedge clk_in);
  endtask : reset
  task automatic go(input logic [1:0] m);
    @(posedge clk_in);
    preq <= m;
    repeat (3) @(posedge clk_in);
  endtask : go
  task automatic wake(output int n);
    @(posedge clk_in);
    preq <= CSM_PWR_RUN;
    for (n = 0; n < 400 && cpu !== 1'b1; n++)
      @(posedge clk_in);
    if (n == 400)
    begin
      mismatches++;
      $display("[FAIL] %0t wakeup timeout", $time);
      end_sim();
    end
  endtask : wake
  task automatic tog(output int n);
    logic p;
    n = 0;
    p = sclk;
    repeat (8)
    begin
      @(posedge clk_in);
      n += (sclk !== p);
      p = sclk;
    end
  endtask : tog
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    chk(post_divide_select, RFD_RST);
    chk(byp, 1'b0);
    chk(crystal_drive_out, 1'b1);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rdat, 32'h0000_0100);
    apb(1'b1, ADDR_CTRL, 32'h0000_7300);
    chk(feedback_multiplier, 3'h7);
    chk(post_divide_select, 3'h3);
    chk(sen, 1'b1);
    apb(1'b0, 32'h0000_0010, 32'h0);
    chk(rerr, 1'b1);
    $display("test regs done");
  endtask : t_regs
  task automatic t_low;
    int n;
    logic [3:0] pl;
    for (int m = 1; m < 3; m++)
    begin
      pl = (m == 1) ? 4'h6 : 4'h9;
      plocal <= pl;
      go(m[1:0]);
      chk({cpu, fl, ram}, 3'h0);
      chk(pce, pl);
      wake(n);
      rng(n, 18, 20);
      chk(pce, pl);
    end
    $display("test low power done");
  endtask : t_low
  task automatic t_stop;
    int n;
    int t;
    int sel[5] = '{0, 1, 2, 3, 2};
    int fst[5] = '{0, 0, 0, 0, 1};
    int lo[5] = '{19, 19, 25, 32, 18};
    int hi[5] = '{21, 21, 29, 36, 20};
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, ADDR_CTRL, (sel[i] << B_STP) | (fst[i] << B_FAST_WAKEUP_SEL) | ((1 + fst[i]) << B_RFD));
      go(CSM_PWR_STOP);
      chk({cpu, fl, ram, pce}, 7'h0);
      chk(sen, sel[i] < 2);
      chk(oen, sel[i] < 3);
      tog(t);
      chk(t > 0, sel[i] == 0);
      wake(n);
      rng(n, lo[i], hi[i]);
    end
    apb(1'b1, ADDR_CTRL, 32'h140);
    tog(t);
    chk(t, 0);
    chk(sclk, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h100);
    tog(t);
    chk(t > 2, 1);
    $display("test stop done");
  endtask : t_stop
  task automatic t_modes;
    int n;
    xsel <= 1'b0;
    reset(2'h3);
    chk(crystal_drive_out, 1'b0);
    chk(byp, 1'b0);
    xsel <= 1'b1;
    for (int s = 1; s < 3; s++)
    begin
      reset(s[1:0]);
      chk(byp, s == 2);
      chk(sen, s != 2);
      apb(1'b1, ADDR_CTRL, 32'h0000_750C);
      if (s == 1)
        chk(feedback_multiplier, 3'h0);
      chk(post_divide_select, 3'h0);
      strap <= 2'h0;
      repeat (2) @(posedge clk_in);
      chk(byp, s == 2);
    end
    go(CSM_PWR_STOP);
    wake(n);
    rng(n, 18, 20);
    $display("test modes done");
  endtask : t_modes
  initial
  begin
    reset(2'h0);
    t_regs();
    t_low();
    t_stop();
    t_modes();
    end_sim();
  end
endmodule : csm_clock_ctrl_tb_top
`default_nettype wire
